// >>> nibble_swap_xor_direction_ops_test.sv
`timescale 1ns/1ps
`include "nsx_regs.svh"
module nibble_swap_xor_direction_ops_test;
import nsx_pkg::*;
logic clk_in = 1'b0;
logic rst_in = 1'b1;
logic valid_in = 1'b0;
nsx_op_t op_in = NSX_OP_NONE;
logic dest_in = 1'b0;
logic [4:0] addr_in = 5'h00;
logic [7:0] imm_in = 8'h00;
logic [7:0] file_rd_in = 8'h00;
logic [4:0] file_addr_out;
logic file_we_out;
logic [7:0] file_wd_out;
logic [7:0] acc_out;
logic [7:0] dir_out;
logic zero_out;
logic done_out;
int fails = 0;
int n_tests = 0;
int cycles = 0;
logic [15:0] seed = 16'h0047;
logic [7:0] m_acc = `NSX_ACC_RESET;
logic [7:0] m_dir = `NSX_DIR_RESET;
logic m_zero = `NSX_ZERO_RESET;
logic m_done = 1'b0;
nsx_op_t ops [5] = '{NSX_OP_NONE, NSX_OP_SWAP, NSX_OP_DIR, NSX_OP_XORK,
    NSX_OP_XORF};
nsx_core #(.WIDTH(8), .ADDR_W(5)) nsx_core_inst (.clk_in(clk_in),
    .rst_in(rst_in), .valid_in(valid_in), .op_in(op_in),
    .dest_in(dest_in), .addr_in(addr_in), .imm_in(imm_in),
    .file_rd_in(file_rd_in), .file_addr_out(file_addr_out),
    .file_we_out(file_we_out), .file_wd_out(file_wd_out),
    .acc_out(acc_out), .dir_out(dir_out), .zero_out(zero_out),
    .done_out(done_out));
////////////////////////////////////////////////////////////////////////
initial begin
    forever #5 clk_in = ~clk_in;
end
function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
function automatic logic [7:0] calc(input nsx_op_t o,
    input logic [7:0] a, input logic [7:0] f, input logic [7:0] k);
    case (o)
        NSX_OP_SWAP: return {f[3:0], f[7:4]};
        NSX_OP_XORK: return a ^ k;
        default: return a ^ f;
    endcase
endfunction
task automatic check(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    n_tests++;
    if (seen !== exp) begin
        fails++;
        $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
endtask
task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
// registered outputs checked one cycle late, so back-to-back ops chain
task automatic op(input nsx_op_t o, input logic v, input logic d,
    input logic [4:0] a, input logic [7:0] k, input logic [7:0] f);
    logic [7:0] r;
    logic we;
    @(posedge clk_in);
    valid_in <= v;
    op_in <= o;
    dest_in <= d;
    addr_in <= a;
    imm_in <= k;
    file_rd_in <= f;
    @(negedge clk_in);
    check(acc_out, m_acc, "acc");
    check(dir_out, m_dir, "dir");
    check({7'h00, zero_out}, {7'h00, m_zero}, "zero");
    check({7'h00, done_out}, {7'h00, m_done}, "done");
    check({3'h0, file_addr_out}, {3'h0, a}, "addr");
    r = calc(o, m_acc, f, k);
    we = v && d && (o == NSX_OP_SWAP || o == NSX_OP_XORF);
    check({7'h00, file_we_out}, {7'h00, we}, "we");
    if (we) check(file_wd_out, r, "wd");
    m_done = v;
    if (v) begin
        if (o == NSX_OP_DIR) m_dir = m_acc;
        if (((o == NSX_OP_SWAP || o == NSX_OP_XORF) && !d)
            || o == NSX_OP_XORK) m_acc = r;
        if (o == NSX_OP_XORK || o == NSX_OP_XORF) m_zero = (r == 8'h00);
    end
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    int idx;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    op(NSX_OP_XORK, 1'b1, 1'b0, 5'h00, 8'h3C, 8'h00);
    op(NSX_OP_XORK, 1'b1, 1'b0, 5'h00, 8'h3C, 8'h00);
    op(NSX_OP_XORF, 1'b1, 1'b0, 5'h1F, 8'h00, 8'h00);
    op(NSX_OP_SWAP, 1'b1, 1'b0, 5'h03, 8'h00, 8'hA5);
    op(NSX_OP_DIR, 1'b1, 1'b1, `NSX_DIR_ADDR, 8'h00, 8'h00);
    op(NSX_OP_XORF, 1'b1, 1'b1, 5'h1F, 8'h00, 8'h5A);
    op(NSX_OP_SWAP, 1'b1, 1'b1, 5'h00, 8'h00, 8'h0F);
    op(NSX_OP_XORK, 1'b0, 1'b0, 5'h00, 8'hFF, 8'h00);
    op(NSX_OP_NONE, 1'b1, 1'b1, 5'h01, 8'hFF, 8'hFF);
    $display("corner cases done");
    for (int i = 0; i < 300; i++) begin
        seed = lfsr(seed);
        idx = int'(seed[7:0]) % 5;
        seed = lfsr(lfsr(lfsr(lfsr(seed))));
        op(ops[idx], seed[8] | seed[9], seed[10], seed[15:11], seed[7:0],
            8'(lfsr(seed) >> 8));
    end
    op(NSX_OP_NONE, 1'b0, 1'b0, 5'h00, 8'h00, 8'h00);
    $display("random ops done");
    test_done;
end
always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
        fails++;
        test_done;
    end
end
endmodule // nibble_swap_xor_direction_ops_test

// >>> nsx_alu.sv
`timescale 1ns/1ps
`include "nsx_regs.svh"
module nsx_alu #(
    parameter int WIDTH = 8
) (
    input wire nsx_pkg::nsx_op_t op_in,
    input wire logic [WIDTH-1:0] acc_in,
    input wire logic [WIDTH-1:0] file_in,
    input wire logic [WIDTH-1:0] imm_in,
    output logic [WIDTH-1:0] result_out,
    output logic zero_out
);
    import nsx_pkg::*;
    localparam int HALF = WIDTH / 2;
    if (WIDTH != 8) begin : g_width_check
        $error("nsx_alu: width must be 8");
    end
    always_comb begin
        unique case (op_in)
            NSX_OP_SWAP: result_out = {file_in[HALF-1:0],
                file_in[WIDTH-1:HALF]};
            NSX_OP_DIR: result_out = acc_in;
            NSX_OP_XORK: result_out = acc_in ^ imm_in;
            NSX_OP_XORF: result_out = acc_in ^ file_in;
            NSX_OP_NONE: result_out = acc_in;
            default: result_out = acc_in;
        endcase
    end
    assign zero_out = (result_out == '0);
endmodule // nsx_alu

// >>> nsx_core.sv
`timescale 1ns/1ps
`include "nsx_regs.svh"
module nsx_core #(
    parameter int WIDTH = 8,
    parameter int ADDR_W = 5
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire nsx_pkg::nsx_op_t op_in,
    input wire logic dest_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [WIDTH-1:0] imm_in,
    input wire logic [WIDTH-1:0] file_rd_in,
    output logic [ADDR_W-1:0] file_addr_out,
    output logic file_we_out,
    output logic [WIDTH-1:0] file_wd_out,
    output logic [WIDTH-1:0] acc_out,
    output logic [WIDTH-1:0] dir_out,
    output logic zero_out,
    output logic done_out
);
    import nsx_pkg::*;
    if (WIDTH != 8 || ADDR_W != 5) begin : g_size_check
        $error("nsx_core: 8/5 only");
    end
    ////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] acc_reg;
    logic [WIDTH-1:0] dir_reg;
    logic zero_reg;
    logic done_reg;
    logic [WIDTH-1:0] result;
    logic res_zero;
    logic to_acc;
    logic to_file;
    logic upd_zero;

    nsx_alu #(.WIDTH(WIDTH)) u_alu (
        .op_in(op_in),
        .acc_in(acc_reg),
        .file_in(file_rd_in),
        .imm_in(imm_in),
        .result_out(result),
        .zero_out(res_zero)
    );

    // file read is combinational: the caller presents file_rd_in
    // for addr_in in the same cycle as valid_in
    assign file_addr_out = addr_in;
    always_comb begin
        to_acc = 1'b0;
        to_file = 1'b0;
        upd_zero = 1'b0;
        if (valid_in) begin
            unique case (op_in)
                NSX_OP_SWAP: begin
                    to_acc = (dest_in == `NSX_DEST_ACC);
                    to_file = (dest_in == `NSX_DEST_FILE);
                end
                NSX_OP_XORF: begin
                    to_acc = (dest_in == `NSX_DEST_ACC);
                    to_file = (dest_in == `NSX_DEST_FILE);
                    upd_zero = 1'b1;
                end
                NSX_OP_XORK: begin
                    to_acc = 1'b1;
                    upd_zero = 1'b1;
                end
                NSX_OP_DIR: begin
                end
                NSX_OP_NONE: begin
                end
                default: begin
                end
            endcase
        end
    end
    assign file_we_out = to_file;
    assign file_wd_out = result;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_reg <= `NSX_ACC_RESET;
        end else if (to_acc) begin
            acc_reg <= result;
        end
    end
    // only one direction register exists, so the address is implicit
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dir_reg <= `NSX_DIR_RESET;
        end else if (valid_in && op_in == NSX_OP_DIR) begin
            dir_reg <= acc_reg;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            zero_reg <= `NSX_ZERO_RESET;
        end else if (upd_zero) begin
            zero_reg <= res_zero;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= valid_in;
        end
    end
    assign acc_out = acc_reg;
    assign dir_out = dir_reg;
    assign zero_out = zero_reg;
    assign done_out = done_reg;
    ////////////////////////////////////////////////////////////////
    property p_swap_nibbles;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_SWAP && dest_in
        |-> file_we_out && file_wd_out == {file_rd_in[3:0], file_rd_in[7:4]};
    endproperty
    a_swap_nibbles: assert property (p_swap_nibbles)
        else $error("swap result wrong");
    property p_swap_flags;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_SWAP |=> $stable(zero_reg);
    endproperty
    a_swap_flags: assert property (p_swap_flags)
        else $error("swap touched zero");
    property p_swap_acc;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_SWAP && !dest_in
        |=> !$past(file_we_out)
            && acc_reg == {$past(file_rd_in[3:0]), $past(file_rd_in[7:4])};
    endproperty
    a_swap_acc: assert property (p_swap_acc)
        else $error("swap to acc wrong");
    property p_dir_load;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_DIR
        |=> dir_reg == $past(acc_reg) && $stable(zero_reg)
            && $stable(acc_reg);
    endproperty
    a_dir_load: assert property (p_dir_load)
        else $error("direction load wrong");
    property p_xork;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_XORK
        |=> acc_reg == ($past(acc_reg) ^ $past(imm_in));
    endproperty
    a_xork: assert property (p_xork)
        else $error("immediate xor wrong");
    property p_xorf_file;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_XORF && dest_in
        |-> file_we_out && file_wd_out == (acc_reg ^ file_rd_in)
            ##1 $stable(acc_reg);
    endproperty
    a_xorf_file: assert property (p_xorf_file)
        else $error("file xor wrong");
    property p_xorf_acc;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_XORF && !dest_in
        |-> !file_we_out ##1 acc_reg == ($past(acc_reg) ^ $past(file_rd_in));
    endproperty
    a_xorf_acc: assert property (p_xorf_acc)
        else $error("file xor dest wrong");
    property p_zero;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && (op_in == NSX_OP_XORK || op_in == NSX_OP_XORF)
        |=> zero_reg == ($past(result) == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");
    // a stray write strobe would corrupt a file register silently
    property p_we_only;
        @(posedge clk_in) disable iff (rst_in)
        file_we_out |-> valid_in && dest_in
            && (op_in == NSX_OP_SWAP || op_in == NSX_OP_XORF);
    endproperty
    a_we_only: assert property (p_we_only)
        else $error("unexpected file write");
    property p_swap_keep_acc;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_SWAP && dest_in |=> $stable(acc_reg);
    endproperty
    a_swap_keep_acc: assert property (p_swap_keep_acc)
        else $error("swap to file changed acc");
    property p_dir_no_write;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_DIR |-> !file_we_out;
    endproperty
    a_dir_no_write: assert property (p_dir_no_write)
        else $error("direction load wrote file");
    property p_xork_no_write;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_XORK |-> !file_we_out;
    endproperty
    a_xork_no_write: assert property (p_xork_no_write)
        else $error("immediate xor wrote file");
    property p_xorf_addr;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_XORF |-> file_addr_out == addr_in;
    endproperty
    a_xorf_addr: assert property (p_xorf_addr)
        else $error("file xor address wrong");
    property p_zero_hold;
        @(posedge clk_in) disable iff (rst_in)
        !(valid_in && (op_in == NSX_OP_XORK || op_in == NSX_OP_XORF))
        |=> $stable(zero_reg);
    endproperty
    a_zero_hold: assert property (p_zero_hold)
        else $error("zero changed without xor");
    property p_zero_set;
        @(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_XORK && acc_reg == imm_in
        |=> zero_reg;
    endproperty
    a_zero_set: assert property (p_zero_set)
        else $error("zero not set");
    c_swap: cover property (@(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_SWAP && dest_in);
    c_dir: cover property (@(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_DIR);
    c_xork_zero: cover property (@(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_XORK ##1 zero_reg);
    c_xorf_acc: cover property (@(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_XORF && !dest_in);
    c_swap_acc: cover property (@(posedge clk_in) disable iff (rst_in)
        valid_in && op_in == NSX_OP_SWAP && !dest_in);
endmodule // nsx_core

// >>> nsx_pkg.sv
package nsx_pkg;
    typedef enum logic [4:0] {
        NSX_OP_NONE = 5'b00001,
        NSX_OP_SWAP = 5'b00010,
        NSX_OP_DIR = 5'b00100,
        NSX_OP_XORK = 5'b01000,
        NSX_OP_XORF = 5'b10000
    } nsx_op_t;
endpackage

// >>> nsx_regs.svh
`ifndef NSX_REGS_SVH
`define NSX_REGS_SVH
// Operation
// - nibble swap sends file bits 3:0 to 7:4 and 7:4 to 3:0, flags kept.
// - swap: destination 0 writes the accumulator, 1 the file register.
// - direction load copies acc into direction register 6, flags kept.
// - acc xor an 8-bit literal goes to the accumulator and updates zero.
// - acc xor file register 0 to 31 updates zero, other flags kept.
// - file xor: destination 0 writes the accumulator, 1 the file register.
`define NSX_DIR_ADDR 5'h06
`define NSX_ACC_RESET 8'h00
`define NSX_DIR_RESET 8'hFF
`define NSX_ZERO_RESET 1'b0
`define NSX_DEST_ACC 1'b0
`define NSX_DEST_FILE 1'b1
`endif
